// *** src/tbcr_pkg.sv ***
/*
 * Shared constants and types of the two-byte command register map:
 * command codes, status and control bit positions, update-mode commands
 * and state encodings.
 * Assumes a single 125 MHz system clock and an open-drain I2C pair.
 */
package tbcr_pkg;

  // i2c slave address; the value is arbitrary
  localparam logic [6:0]  DEV_ADDR       = 7'h2A;
  localparam logic        RW_READ        = 1'b1;
  localparam logic [2:0]  LAST_BIT       = 3'h7;

  // command codes, low byte at the even code, high byte at the odd one
  localparam logic [7:0]  CMD_STATUS     = 8'h00;
  localparam logic [7:0]  CMD_HW_VER     = 8'h04;
  localparam logic [7:0]  CMD_FW_VER     = 8'h06;
  localparam logic [7:0]  CMD_FAULT      = 8'h08;
  localparam logic [7:0]  CMD_BUS_V      = 8'h0A;
  localparam logic [7:0]  CMD_BUS_I      = 8'h0C;
  localparam logic [7:0]  CMD_MEAN_V     = 8'h12;
  localparam logic [7:0]  CMD_MEAN_I     = 8'h14;
  localparam logic [7:0]  CMD_TEMP_INT   = 8'h16;
  localparam logic [7:0]  CMD_TEMP_EXT   = 8'h18;
  localparam logic [7:0]  CMD_CHG_FAULT  = 8'h1A;
  localparam logic [7:0]  CMD_CONTROL    = 8'h1C;
  localparam logic [7:0]  CMD_CONTROL_HI = 8'h1D;

  localparam logic [15:0] FW_VERSION     = 16'h0104;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] CUTOFF_MV      = 16'h0AF0;

  // status word bit positions
  localparam int ST_FAULT      = 15;
  localparam int ST_RSVD_HI    = 14;
  localparam int ST_RSVD_LO    = 13;
  localparam int ST_DRAIN_TERM = 12;
  localparam int ST_PULSE      = 11;
  localparam int ST_CP         = 10;
  localparam int ST_CI         = 9;
  localparam int ST_CHG_TERM   = 8;
  localparam int ST_CHARGING   = 7;
  localparam int ST_REMOTE     = 6;
  localparam int ST_SUPPLY_SRC = 5;
  localparam int ST_GAUGE_ON   = 4;
  localparam int ST_OUTSIDE_OK = 3;
  localparam int ST_CALIB      = 2;
  localparam int ST_UNDERV     = 1;
  localparam int ST_BATTERY    = 0;

  // control word bit positions
  localparam int CTL_CI     = 0;
  localparam int CTL_CP     = 1;
  localparam int CTL_PULSE  = 2;
  localparam int CTL_CHARGE = 3;

  // first byte of a write while in update mode
  localparam logic [7:0]  UPD_BEGIN  = 8'hA0;
  localparam logic [7:0]  UPD_DATA   = 8'hA1;
  localparam logic [7:0]  UPD_FINISH = 8'hA2;

  localparam logic [1:0]  SW_LOADER  = 2'h1;

  // synchronised pin vector
  localparam int          SYNC_W     = 4;
  localparam int          PIN_SCL    = 0;
  localparam int          PIN_SDA    = 1;
  localparam int          PIN_SW     = 2;
  localparam logic [3:0]  SYNC_RST   = 4'h3;

  typedef enum logic [2:0] {
    S_IDLE     = 3'h0,
    S_ADDR     = 3'h1,
    S_ADDR_ACK = 3'h2,
    S_RX       = 3'h3,
    S_RX_ACK   = 3'h4,
    S_TX       = 3'h5,
    S_TX_ACK   = 3'h6
  } tbcr_bus_st_t;

  typedef enum logic [1:0] {
    U_OFF   = 2'h0,
    U_ERASE = 2'h1,
    U_LOAD  = 2'h2,
    U_RESET = 2'h3
  } tbcr_upd_st_t;

endpackage : tbcr_pkg

// *** src/tbcr_pin_if.sv ***
/*
 * Carries raw pin levels into the synchroniser and the filtered levels back.
 * Assumes both ends run on i_clk_sys.
 */
interface tbcr_pin_if;
  logic [tbcr_pkg::SYNC_W-1:0] raw;
  logic [tbcr_pkg::SYNC_W-1:0] stable;
  modport sync (input raw, output stable);
  modport core (output raw, input stable);
endinterface : tbcr_pin_if

// *** src/tbcr_pin_sync.sv ***
/*
 * Three-stage pin synchroniser: a level is taken once stages two and three agree.
 * Assumes asynchronous pins; i2c lines idle high at reset.
 */
module tbcr_pin_sync (
  input  wire logic   i_clk_sys,
  input  wire logic   i_rst_n,
  tbcr_pin_if.sync    pins
);
  logic [tbcr_pkg::SYNC_W-1:0] st1_reg, st2_reg, st3_reg, out_reg;
  logic [tbcr_pkg::SYNC_W-1:0] out_next;

  // stage one feeds stage two only, so a glitch of a single clock never passes the agree test
  always_comb begin
    out_next = ((st2_reg ~^ st3_reg) & st3_reg) | ((st2_reg ^ st3_reg) & out_reg);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st1_reg <= tbcr_pkg::SYNC_RST;
      st2_reg <= tbcr_pkg::SYNC_RST;
      st3_reg <= tbcr_pkg::SYNC_RST;
      out_reg <= tbcr_pkg::SYNC_RST;
    end else begin
      st1_reg <= pins.raw;
      st2_reg <= st1_reg;
      st3_reg <= st2_reg;
      out_reg <= out_next;
    end
  end

  assign pins.stable = out_reg;
endmodule : tbcr_pin_sync

// *** src/tbcr_regmap.sv ***
/*
 * I2C slave holding the 16-bit command map, discharge gating, and update mode.
 * Assumes the host drives SCL without stretching and the erase engine answers.
 */
// Function
// - every function is one 16-bit, two-byte command
// - consecutive code pair selects each command
// - command code transfer, then data transfer
// - status reads show live board state
// - update mode erases, programs, then resets
// - stays in update mode, accepts recovery update
// - status high bits 6:5 reserved, bit7 fault
// - cutoff flag set when discharge hits 2800 mV
// - undervoltage below 2800 blocks discharge, clears above
// - fault bit set when any fault present
module tbcr_regmap (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe_n,
  input  wire logic [1:0]  i_mode_select_switch,
  input  wire logic [15:0] i_meas_mv,
  input  wire logic        i_meas_valid,
  input  wire logic [15:0] i_fault_flags,
  input  wire logic [15:0] i_hardware_version,
  input  wire logic [15:0] i_bus_voltage_mv,
  input  wire logic [15:0] i_bus_current_ma,
  input  wire logic [15:0] i_mean_voltage_mv,
  input  wire logic [15:0] i_mean_current_ma,
  input  wire logic [15:0] i_onboard_temperature,
  input  wire logic [15:0] i_remote_temperature,
  input  wire logic [15:0] i_charger_fault,
  input  wire logic        i_charge_term,
  input  wire logic        i_remote_sensor_present,
  input  wire logic        i_outside_supply_ok,
  input  wire logic        i_calib_regulator_on,
  input  wire logic        i_battery_connected,
  input  wire logic        i_erase_done,
  output logic             o_const_current_drain_active,
  output logic             o_const_power_drain_active,
  output logic             o_pulse_drain_active,
  output logic             o_charge_active,
  output logic             o_update_mode,
  output logic             o_erase_start,
  output logic [7:0]       o_prog_byte,
  output logic             o_prog_valid,
  output logic             o_self_reset
);
  tbcr_pin_if pins ();
  assign pins.raw = {i_mode_select_switch, i_sda, i_scl};
  tbcr_pin_sync u_sync (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .pins(pins));
  logic       scl, sda, loader, start_ev, stop_ev, rise, fall;
  logic       scl_q_reg, sda_q_reg, loader_q_reg;
  assign scl    = pins.stable[tbcr_pkg::PIN_SCL];
  assign sda    = pins.stable[tbcr_pkg::PIN_SDA];
  assign loader = (pins.stable[tbcr_pkg::PIN_SW+1:tbcr_pkg::PIN_SW] == tbcr_pkg::SW_LOADER);
  assign start_ev = scl & scl_q_reg & sda_q_reg & ~sda;
  assign stop_ev  = scl & scl_q_reg & ~sda_q_reg & sda;
  assign rise     = scl & ~scl_q_reg;
  assign fall     = ~scl & scl_q_reg;
  tbcr_pkg::tbcr_bus_st_t st_reg, st_next;
  tbcr_pkg::tbcr_upd_st_t upd_reg, upd_next;
  logic [2:0]  bit_reg, bit_next;
  logic [7:0]  shift_reg, shift_next, ptr_reg, ptr_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic        rw_reg, rw_next, first_reg, first_next, phase_reg, phase_next;
  logic        oe_n_reg, oe_n_next, underv_reg, underv_next, term_reg, term_next;
  logic        ci_reg, ci_next, cp_reg, cp_next, pulse_reg, pulse_next, chg_reg, chg_next;
  logic [7:0]  upd_cmd_reg, upd_cmd_next, prog_byte_reg, prog_byte_next;
  logic        erase_reg, erase_next, prog_v_reg, prog_v_next, sreset_reg, sreset_next, mode_reg, mode_next;
  logic        rx_commit, drain_on, cutoff_hit, updating;
  logic [7:0]  rx_byte, rd_byte;
  logic [15:0] status_word, rd_word;
  assign updating   = (upd_reg != tbcr_pkg::U_OFF);
  assign rx_commit  = (st_reg == tbcr_pkg::S_RX) && rise && (bit_reg == tbcr_pkg::LAST_BIT);
  assign rx_byte    = {shift_reg[6:0], sda};
  assign drain_on   = ci_reg | cp_reg | pulse_reg;
  assign cutoff_hit = i_meas_valid && (i_meas_mv <= tbcr_pkg::CUTOFF_MV) && drain_on;
  // status is assembled from present state at each read, never latched
  always_comb begin
    status_word                          = '0;
    status_word[tbcr_pkg::ST_FAULT]      = |i_fault_flags;
    status_word[tbcr_pkg::ST_RSVD_HI:tbcr_pkg::ST_RSVD_LO] = 2'h0;
    status_word[tbcr_pkg::ST_DRAIN_TERM] = term_reg;
    status_word[tbcr_pkg::ST_PULSE]      = pulse_reg;
    status_word[tbcr_pkg::ST_CP]         = cp_reg;
    status_word[tbcr_pkg::ST_CI]         = ci_reg;
    status_word[tbcr_pkg::ST_CHG_TERM]   = i_charge_term;
    status_word[tbcr_pkg::ST_CHARGING]   = chg_reg;
    status_word[tbcr_pkg::ST_REMOTE]     = i_remote_sensor_present;
    status_word[tbcr_pkg::ST_SUPPLY_SRC] = 1'b1;
    status_word[tbcr_pkg::ST_GAUGE_ON]   = 1'b1;
    status_word[tbcr_pkg::ST_OUTSIDE_OK] = i_outside_supply_ok;
    status_word[tbcr_pkg::ST_CALIB]      = i_calib_regulator_on;
    status_word[tbcr_pkg::ST_UNDERV]     = underv_reg;
    status_word[tbcr_pkg::ST_BATTERY]    = i_battery_connected;
  end
  always_comb begin
    case ({ptr_reg[7:1], 1'b0})
      tbcr_pkg::CMD_STATUS:    rd_word = status_word;
      tbcr_pkg::CMD_HW_VER:    rd_word = i_hardware_version;
      tbcr_pkg::CMD_FW_VER:    rd_word = tbcr_pkg::FW_VERSION;
      tbcr_pkg::CMD_FAULT:     rd_word = i_fault_flags;
      tbcr_pkg::CMD_BUS_V:     rd_word = i_bus_voltage_mv;
      tbcr_pkg::CMD_BUS_I:     rd_word = i_bus_current_ma;
      tbcr_pkg::CMD_MEAN_V:    rd_word = i_mean_voltage_mv;
      tbcr_pkg::CMD_MEAN_I:    rd_word = i_mean_current_ma;
      tbcr_pkg::CMD_TEMP_INT:  rd_word = i_onboard_temperature;
      tbcr_pkg::CMD_TEMP_EXT:  rd_word = i_remote_temperature;
      tbcr_pkg::CMD_CHG_FAULT: rd_word = i_charger_fault;
      tbcr_pkg::CMD_CONTROL:   rd_word = ctrl_reg;
      default:                 rd_word = '0;
    endcase
    rd_byte = ptr_reg[0] ? rd_word[15:8] : rd_word[7:0];
  end
  // bus engine, command pointer, control word and measurement flags
  always_comb begin
    st_next = st_reg;  bit_next = bit_reg;  shift_next = shift_reg;  ptr_next = ptr_reg;
    rw_next = rw_reg;  first_next = first_reg;  phase_next = phase_reg;  oe_n_next = oe_n_reg;
    ctrl_next = ctrl_reg;
    case (st_reg)
      tbcr_pkg::S_ADDR: if (rise) begin
        shift_next = rx_byte;
        bit_next   = bit_reg + 3'h1;
        if (bit_reg == tbcr_pkg::LAST_BIT) begin
          st_next    = (shift_reg[6:0] == tbcr_pkg::DEV_ADDR) ? tbcr_pkg::S_ADDR_ACK : tbcr_pkg::S_IDLE;
          rw_next    = sda;
          first_next = (sda != tbcr_pkg::RW_READ);
        end
      end
      tbcr_pkg::S_ADDR_ACK, tbcr_pkg::S_RX_ACK: if (fall) begin
        phase_next = ~phase_reg;
        oe_n_next  = phase_reg;
        if (phase_reg) begin
          if (st_reg == tbcr_pkg::S_ADDR_ACK && rw_reg == tbcr_pkg::RW_READ) begin
            st_next    = tbcr_pkg::S_TX;
            shift_next = rd_byte;
            oe_n_next  = rd_byte[7];
            ptr_next   = ptr_reg + 8'h01;
          end else begin
            st_next = tbcr_pkg::S_RX;
          end
        end
      end
      tbcr_pkg::S_RX: if (rise) begin
        shift_next = rx_byte;
        bit_next   = bit_reg + 3'h1;
        if (rx_commit) begin
          st_next    = tbcr_pkg::S_RX_ACK;
          first_next = 1'b0;
          if (first_reg) begin
            ptr_next = rx_byte;
          end else if (!updating) begin
            if (ptr_reg == tbcr_pkg::CMD_CONTROL)    ctrl_next[7:0]  = rx_byte;
            if (ptr_reg == tbcr_pkg::CMD_CONTROL_HI) ctrl_next[15:8] = rx_byte;
            ptr_next = ptr_reg + 8'h01;
          end
        end
      end
      tbcr_pkg::S_TX: begin
        if (rise) begin
          bit_next = bit_reg + 3'h1;
          if (bit_reg == tbcr_pkg::LAST_BIT) st_next = tbcr_pkg::S_TX_ACK;
        end else if (fall) begin
          shift_next = {shift_reg[6:0], 1'b0};
          oe_n_next  = shift_reg[6];
        end
      end
      tbcr_pkg::S_TX_ACK: begin
        if (fall && !phase_reg) oe_n_next = 1'b1;
        if (rise) begin
          phase_next = 1'b1;
          if (sda) st_next = tbcr_pkg::S_IDLE;
        end else if (fall && phase_reg) begin
          phase_next = 1'b0;
          st_next    = tbcr_pkg::S_TX;
          shift_next = rd_byte;
          oe_n_next  = rd_byte[7];
          ptr_next   = ptr_reg + 8'h01;
        end
      end
      default: ;
    endcase
    if (start_ev) begin
      st_next = tbcr_pkg::S_ADDR;  bit_next = '0;  phase_next = 1'b0;  oe_n_next = 1'b1;
    end else if (stop_ev) begin
      st_next = tbcr_pkg::S_IDLE;  phase_next = 1'b0;  oe_n_next = 1'b1;
    end
    // a drain that reaches the cutoff stops and leaves its flag behind
    if (cutoff_hit) begin
      ctrl_next[tbcr_pkg::CTL_CI]    = 1'b0;
      ctrl_next[tbcr_pkg::CTL_CP]    = 1'b0;
      ctrl_next[tbcr_pkg::CTL_PULSE] = 1'b0;
    end
    underv_next = underv_reg;
    if (i_meas_valid && i_meas_mv < tbcr_pkg::CUTOFF_MV) underv_next = 1'b1;
    else if (i_meas_valid && i_meas_mv > tbcr_pkg::CUTOFF_MV) underv_next = 1'b0;
    // the flag clears on any data byte written, but a cutoff in that cycle wins
    term_next = (term_reg && !(rx_commit && !first_reg)) || cutoff_hit;
    ci_next    = ctrl_reg[tbcr_pkg::CTL_CI]    && !underv_reg && !updating;
    cp_next    = ctrl_reg[tbcr_pkg::CTL_CP]    && !underv_reg && !updating;
    pulse_next = ctrl_reg[tbcr_pkg::CTL_PULSE] && !underv_reg && !updating;
    chg_next   = ctrl_reg[tbcr_pkg::CTL_CHARGE] && !updating;
  end
  // update mode: entered on the switch reaching the loader position
  always_comb begin
    upd_next = upd_reg;  upd_cmd_next = upd_cmd_reg;  prog_byte_next = prog_byte_reg;
    erase_next = 1'b0;  prog_v_next = 1'b0;  sreset_next = 1'b0;
    case (upd_reg)
      tbcr_pkg::U_OFF: if (loader && !loader_q_reg) begin
        upd_next   = tbcr_pkg::U_ERASE;
        erase_next = 1'b1;
      end
      tbcr_pkg::U_ERASE: if (i_erase_done) upd_next = tbcr_pkg::U_LOAD;
      tbcr_pkg::U_LOAD: if (rx_commit) begin
        if (first_reg) begin
          upd_cmd_next = rx_byte;
          if (rx_byte == tbcr_pkg::UPD_BEGIN) begin
            upd_next   = tbcr_pkg::U_ERASE;
            erase_next = 1'b1;
          end else if (rx_byte == tbcr_pkg::UPD_FINISH) begin
            upd_next = tbcr_pkg::U_RESET;
          end
        end else if (upd_cmd_reg == tbcr_pkg::UPD_DATA) begin
          prog_byte_next = rx_byte;
          prog_v_next    = 1'b1;
        end
      end
      tbcr_pkg::U_RESET: begin
        upd_next    = tbcr_pkg::U_OFF;
        sreset_next = 1'b1;
      end
      default: upd_next = tbcr_pkg::U_OFF;
    endcase
    mode_next = (upd_next != tbcr_pkg::U_OFF);
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= tbcr_pkg::S_IDLE;  bit_reg <= '0;  shift_reg <= '0;  ptr_reg <= tbcr_pkg::CMD_STATUS;
      rw_reg <= 1'b0;  first_reg <= 1'b0;  phase_reg <= 1'b0;  oe_n_reg <= 1'b1;
      ctrl_reg <= tbcr_pkg::CTRL_RESET;  underv_reg <= 1'b0;  term_reg <= 1'b0;
      ci_reg <= 1'b0;  cp_reg <= 1'b0;  pulse_reg <= 1'b0;  chg_reg <= 1'b0;
      scl_q_reg <= 1'b1;  sda_q_reg <= 1'b1;  loader_q_reg <= 1'b0;
      upd_reg <= tbcr_pkg::U_OFF;  upd_cmd_reg <= '0;  prog_byte_reg <= '0;
      erase_reg <= 1'b0;  prog_v_reg <= 1'b0;  sreset_reg <= 1'b0;  mode_reg <= 1'b0;
    end else begin
      st_reg <= st_next;  bit_reg <= bit_next;  shift_reg <= shift_next;  ptr_reg <= ptr_next;
      rw_reg <= rw_next;  first_reg <= first_next;  phase_reg <= phase_next;  oe_n_reg <= oe_n_next;
      ctrl_reg <= ctrl_next;  underv_reg <= underv_next;  term_reg <= term_next;
      ci_reg <= ci_next;  cp_reg <= cp_next;  pulse_reg <= pulse_next;  chg_reg <= chg_next;
      scl_q_reg <= scl;  sda_q_reg <= sda;  loader_q_reg <= loader;
      upd_reg <= upd_next;  upd_cmd_reg <= upd_cmd_next;  prog_byte_reg <= prog_byte_next;
      erase_reg <= erase_next;  prog_v_reg <= prog_v_next;  sreset_reg <= sreset_next;  mode_reg <= mode_next;
    end
  end
  assign o_sda                        = 1'b0;
  assign o_sda_oe_n                   = oe_n_reg;
  assign o_const_current_drain_active = ci_reg;
  assign o_const_power_drain_active   = cp_reg;
  assign o_pulse_drain_active         = pulse_reg;
  assign o_charge_active              = chg_reg;
  assign o_update_mode                = mode_reg;
  assign o_erase_start                = erase_reg;
  assign o_prog_byte                  = prog_byte_reg;
  assign o_prog_valid                 = prog_v_reg;
  assign o_self_reset                 = sreset_reg;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_underv_set: assert property (i_meas_valid && i_meas_mv < tbcr_pkg::CUTOFF_MV |=> underv_reg)
    else $error("undervoltage flag not set below cutoff");
  a_underv_clear: assert property (i_meas_valid && i_meas_mv > tbcr_pkg::CUTOFF_MV |=> !underv_reg)
    else $error("undervoltage flag not cleared above cutoff");
  a_drain_blocked: assert property (underv_reg |=> !(ci_reg || cp_reg || pulse_reg))
    else $error("discharge active while undervoltage set");
  a_cutoff_term: assert property (cutoff_hit |=> term_reg ##1 !(ci_reg || cp_reg || pulse_reg))
    else $error("cutoff did not stop drain and set flag");
  a_status_fault: assert property (ptr_reg == (tbcr_pkg::CMD_STATUS + 8'h01)
    |-> rd_byte[7] == (|i_fault_flags) && rd_byte[6:5] == 2'h0)
    else $error("status high byte wrong");
  a_cmd_pointer: assert property (rx_commit && first_reg |=> ptr_reg == $past(rx_byte))
    else $error("command code not taken as pointer");
  a_ctrl_low: assert property (rx_commit && !first_reg && !updating && !cutoff_hit && ptr_reg == tbcr_pkg::CMD_CONTROL
    |=> ctrl_reg[7:0] == $past(rx_byte) && ptr_reg == tbcr_pkg::CMD_CONTROL_HI)
    else $error("control low byte write wrong");
  a_upd_entry: assert property (upd_reg == tbcr_pkg::U_OFF && loader && !loader_q_reg
    |=> upd_reg == tbcr_pkg::U_ERASE && o_erase_start)
    else $error("update entry did not start erase");
  a_upd_recover: assert property (upd_reg == tbcr_pkg::U_LOAD && rx_commit && first_reg
    && rx_byte == tbcr_pkg::UPD_BEGIN |=> upd_reg == tbcr_pkg::U_ERASE && o_erase_start)
    else $error("recovery update not accepted");
  a_upd_finish: assert property (upd_reg == tbcr_pkg::U_LOAD && rx_commit && first_reg
    && rx_byte == tbcr_pkg::UPD_FINISH |=> ##1 o_self_reset && !o_update_mode)
    else $error("finish did not reset");
  c_read_tx: cover property (st_reg == tbcr_pkg::S_TX_ACK ##1 st_reg == tbcr_pkg::S_TX);
  c_ctrl_write: cover property (rx_commit && !first_reg && ptr_reg == tbcr_pkg::CMD_CONTROL);
  c_cutoff: cover property (cutoff_hit);
  c_update_done: cover property (o_self_reset);
endmodule : tbcr_regmap

// *** verif/tbcr_host_model.sv ***
/* I2C host adapter model: drives SCL and pulls SDA low one bit at a time.
   Assumes the bench resolves the pulled-up SDA wire from all enables. */
module tbcr_host_model (
  input  wire logic i_clk_sys,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // ten clocks a half period keeps clear of the pin synchroniser delay
  task automatic half();
    repeat (10) @(posedge i_clk_sys);
    #1;
  endtask : half
  // data moves only a few clocks after scl fell, never next to an scl edge
  task automatic bit_cyc(output logic s);
    half();
    o_scl = 1'b1;
    half();
    s = i_sda;
    o_scl = 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask : bit_cyc
  task automatic start();
    o_sda_low = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda_low = 1'b1;
    half();
    o_scl = 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask : start
  task automatic stop();
    o_sda_low = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_sda_low = 1'b0;
    half();
  endtask : stop
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      o_sda_low = ~b[i];
      bit_cyc(s);
    end
    o_sda_low = 1'b0;
    bit_cyc(ack);
  endtask : put_byte
  // the host acks every byte but the last of a read
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(s);
      b[i] = s;
    end
    o_sda_low = ~last;
    bit_cyc(s);
    // a nack already left the line released; stop() takes it from here
    if (!last) o_sda_low = 1'b0;
  endtask : get_byte
endmodule : tbcr_host_model

// *** verif/tb.sv ***
/* Bench for the command register map: the host model reads and writes commands
   while the bench drives measurements, status levels and the switch.
   Assumes the package, the regmap and the host model are compiled first. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CODES [9] = '{8'h08, 8'h04, 8'h0A, 8'h0C, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1A};
  logic        i_clk_sys, i_rst_n, scl, sda_low, sda_w, o_sda, o_sda_oe_n, mval, edone, ack;
  logic        cci, cpd, pul, chg, upd, ers, pv, srst;
  logic [1:0]  sw;
  logic [4:0]  lv;
  logic [7:0]  pb;
  logic [15:0] mv, rd, lf;
  logic [15:0] v [9];
  logic [7:0]  pq [$];
  int          fails, checks_done, n_ers, n_rst;
  assign sda_w = ~(sda_low | ~o_sda_oe_n);
  tbcr_regmap dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_w), .o_sda(o_sda),
    .o_sda_oe_n(o_sda_oe_n), .i_mode_select_switch(sw), .i_meas_mv(mv), .i_meas_valid(mval),
    .i_fault_flags(v[0]), .i_hardware_version(v[1]), .i_bus_voltage_mv(v[2]), .i_bus_current_ma(v[3]),
    .i_mean_voltage_mv(v[4]), .i_mean_current_ma(v[5]), .i_onboard_temperature(v[6]),
    .i_remote_temperature(v[7]), .i_charger_fault(v[8]), .i_charge_term(lv[4]),
    .i_remote_sensor_present(lv[3]), .i_outside_supply_ok(lv[2]), .i_calib_regulator_on(lv[1]),
    .i_battery_connected(lv[0]), .i_erase_done(edone), .o_const_current_drain_active(cci),
    .o_const_power_drain_active(cpd), .o_pulse_drain_active(pul), .o_charge_active(chg),
    .o_update_mode(upd), .o_erase_start(ers), .o_prog_byte(pb), .o_prog_valid(pv), .o_self_reset(srst));
  tbcr_host_model host (.i_clk_sys(i_clk_sys), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  always @(negedge i_clk_sys) begin
    if (pv === 1'b1) pq.push_back(pb);
    n_ers += (ers === 1'b1);
    n_rst += (srst === 1'b1);
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  // drains and charging are off whenever status is predicted
  function automatic logic [15:0] st_exp(input logic [15:0] f, input logic [4:0] l, input logic t, u);
    return {|f, 2'b00, t, 3'b000, l[4], 1'b0, l[3], 2'b11, l[2], l[1], u, l[0]};
  endfunction : st_exp
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic rd_cmd(input logic [7:0] c, output logic [15:0] d);
    host.start();
    host.put_byte({tbcr_pkg::DEV_ADDR, 1'b0}, ack);
    host.put_byte(c, ack);
    host.start();
    host.put_byte({tbcr_pkg::DEV_ADDR, 1'b1}, ack);
    host.get_byte(1'b0, d[7:0]);
    host.get_byte(1'b1, d[15:8]);
    host.stop();
  endtask : rd_cmd
  task automatic wr(input logic [7:0] b0, b1, b2, input int n);
    host.start();
    host.put_byte({tbcr_pkg::DEV_ADDR, 1'b0}, ack);
    host.put_byte(b0, ack);
    if (n > 1) host.put_byte(b1, ack);
    if (n > 2) host.put_byte(b2, ack);
    host.stop();
  endtask : wr
  task automatic meas(input logic [15:0] m);
    mv = m;
    mval = 1'b1;
    @(posedge i_clk_sys) #1;
    mval = 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask : meas
  task automatic wrap_up();
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
  initial begin
    {i_rst_n, mval, edone, mv, lv, fails, checks_done, n_ers, n_rst} = '0;
    sw = 2'h2;
    lf = 16'h002E;
    for (int i = 0; i < 9; i++) begin
      lf = lfsr(lf);
      v[i] = lf;
    end
    repeat (10) @(posedge i_clk_sys);
    #1;
    i_rst_n = 1'b1;
    repeat (6) @(posedge i_clk_sys);
    #1;
    for (int i = 0; i < 9; i++) begin
      rd_cmd(CODES[i], rd);
      cmp("command word", v[i], rd);
    end
    rd_cmd(8'h06, rd);
    cmp("firmware version", 16'h0104, rd);
    for (int k = 0; k < 2; k++) begin
      lf = lfsr(lf);
      v[0] = k ? lf : 16'h0000;
      lv = lf[4:0];
      rd_cmd(8'h00, rd);
      cmp("status", st_exp(v[0], lv, 1'b0, 1'b0), rd);
    end
    wr(8'h1C, 8'h03, 8'h00, 3);
    rd_cmd(8'h1C, rd);
    cmp("control", 16'h0003, rd);
    meas(16'h0B54);
    cmp("drains", 16'h0003, {cpd, cci});
    meas(16'h0AF0);
    cmp("drains at cutoff", 16'h0000, {cpd, cci});
    rd_cmd(8'h00, rd);
    cmp("status cutoff", st_exp(v[0], lv, 1'b1, 1'b0), rd);
    meas(16'h0A8C);
    wr(8'h1C, 8'h01, 8'h00, 2);
    cmp("blocked drain", 16'h0000, cci);
    rd_cmd(8'h00, rd);
    cmp("status low", st_exp(v[0], lv, 1'b0, 1'b1), rd);
    meas(16'h0AF1);
    cmp("drain after rise", 16'h0001, cci);
    wr(8'h1C, 8'h0C, 8'h00, 2);
    cmp("pulse and charge", 16'h000C, {chg, pul, cpd, cci});
    cmp("sda drive", 16'h0000, o_sda);
    sw = 2'h1;
    repeat (12) @(posedge i_clk_sys);
    #1;
    cmp("update entry", 16'h0101, {upd, 7'h00, n_ers[0]});
    cmp("drain in update", 16'h0000, {chg, pul, cci});
    edone = 1'b1;
    wr(tbcr_pkg::UPD_DATA, 8'h5A, 8'hC3, 3);
    wr(tbcr_pkg::UPD_BEGIN, 8'h00, 8'h00, 1);
    repeat (12) @(posedge i_clk_sys);
    #1;
    cmp("recovery erase", 16'h0002, n_ers[15:0]);
    wr(tbcr_pkg::UPD_DATA, 8'h7E, 8'h00, 2);
    wr(tbcr_pkg::UPD_FINISH, 8'h00, 8'h00, 1);
    repeat (5) @(posedge i_clk_sys);
    #1;
    cmp("image bytes", 16'h0003, 16'(pq.size()));
    if (pq.size() == 3) cmp("image", 16'h5AC3, {pq[0], pq[1]});
    if (pq.size() == 3) cmp("image tail", 16'h007E, pq[2]);
    cmp("self reset", 16'h0001, {upd, n_rst[14:0]});
    wrap_up();
  end
endmodule : tb
